// ### design/amx_pkg.sv
// Purpose: Shared constants for the automatic microphone mixer.
// Assumes: Gains are unsigned fractions of full scale, samples signed.
// Notes: Ramp steps are derived from the nominal 48 kHz sample rate.
package amx_pkg;
   localparam int NCH = 8;
   localparam int SW = 24;
   localparam int FW = 16;
   localparam int GW = 24;
   localparam int CW = 16;
   localparam int FIFO_DEPTH = 8;
   localparam int MIX_W = 2 * SW;
   localparam int FADER_FRAC = 12;
   localparam int COEF_FRAC = 16;

   localparam logic [GW-1:0] GAIN_OPEN = 24'hFFFFFF;
   // 0.1 of full scale, i.e. 20 dB down from open
   localparam logic [GW-1:0] GAIN_CLOSED = 24'h19999A;
   localparam logic [GW-1:0] GAIN_RST = GAIN_OPEN;

   localparam int FS_NOM_HZ = 48000;
   localparam int ATTACK_TIME_US = 1000;
   localparam int RELEASE_TIME_MS = 500;
   // Least time rounds up, longest time rounds down
   localparam int ATTACK_SAMPLES =
      (FS_NOM_HZ * ATTACK_TIME_US + 999999) / 1000000;
   localparam int RELEASE_SAMPLES = FS_NOM_HZ * RELEASE_TIME_MS / 1000;
   localparam int GAIN_SPAN = int'(GAIN_OPEN) - int'(GAIN_CLOSED);
   localparam logic [GW-1:0] ATTACK_STEP =
      GW'((GAIN_SPAN + ATTACK_SAMPLES - 1) / ATTACK_SAMPLES);
   localparam logic [GW-1:0] RELEASE_STEP =
      GW'(GAIN_SPAN / RELEASE_SAMPLES);

   localparam int ENV_DECAY_SH = 8;
   localparam int AVG_SH = 10;
   localparam int THR_SH = 2;
   localparam logic [SW-1:0] THR_FLOOR = 24'h000400;
   localparam logic [SW-1:0] ENV_RST = 24'h000000;
   localparam logic [SW-1:0] AVG_RST = 24'h000000;

   localparam logic [17:0] MAX_AUTO_RATE_HZ = 18'h0BBB0;
   localparam logic [2:0] LAST_RST = 3'h0;

   localparam logic [1:0] LED_OFF = 2'h0;
   localparam logic [1:0] LED_BRIGHT = 2'h1;
   localparam logic [1:0] LED_DIM_METER = 2'h2;
   localparam logic [1:0] LED_METER = 2'h3;
   localparam int METER_W = 8;
endpackage : amx_pkg

// ### design/amx_fifo.sv
// Purpose: Small flip-flop FIFO carrying mixed track words.
// Assumes: One clock; clk_en low freezes pointers and storage.
// Notes: Full and empty are exact; ready drops while frozen.
`timescale 1ns/1ps
module amx_fifo #(
   parameter int W = 48,
   parameter int DEPTH = 8
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [W-1:0] wr_data,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [W-1:0] rd_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_r [DEPTH];
   logic [W-1:0] mem_nxt [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;

   assign wr_ready = clk_en && (cnt_r != (AW+1)'(DEPTH));
   assign rd_valid = clk_en && (cnt_r != '0);
   assign rd_data = mem_r[rp_r];
   assign push = wr_valid && wr_ready;
   assign pop = rd_valid && rd_ready;

   always_comb begin
      mem_nxt = mem_r;
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      cnt_nxt = cnt_r;
      if (push) begin
         mem_nxt[wp_r] = wr_data;
         wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
         rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= '0;
         end
      end else if (clk_en) begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
         mem_r <= mem_nxt;
      end
   end
endmodule : amx_fifo

// ### design/amx_chan.sv
// Purpose: Per-input level detector, adaptive threshold and gain ramp.
// Assumes: upd pulses once per accepted sample.
// Notes: Gain moves one step per sample while automixed; with auto off it is set straight to open.
`timescale 1ns/1ps
module amx_chan (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic upd,
   input wire logic auto_on,
   input wire logic want_open,
   input wire logic signed [amx_pkg::SW-1:0] sample,
   output logic [amx_pkg::SW-1:0] env,
   output logic active,
   output logic [amx_pkg::GW-1:0] gain
);
   logic [amx_pkg::SW-1:0] raw, mag, thr;
   logic [amx_pkg::SW-1:0] env_r, env_nxt, avg_r, avg_nxt;
   logic [amx_pkg::GW-1:0] gain_r, gain_nxt;

   assign raw = sample;
   assign mag = raw[amx_pkg::SW-1] ? (~raw + 24'h000001) : raw;
   assign env = env_r;
   assign gain = gain_r;

   always_comb begin
      // Threshold follows the noise floor, saturating on overflow
      if (avg_r[amx_pkg::SW-1 -: amx_pkg::THR_SH] != '0) begin
         thr = '1;
      end else begin
         thr = avg_r << amx_pkg::THR_SH;
      end
      if (thr < amx_pkg::THR_FLOOR) begin
         thr = amx_pkg::THR_FLOOR;
      end
   end
   assign active = env_r > thr;

   always_comb begin
      env_nxt = env_r;
      avg_nxt = avg_r;
      gain_nxt = gain_r;
      if (upd) begin
         env_nxt = (mag > env_r) ? mag
                 : env_r - (env_r >> amx_pkg::ENV_DECAY_SH);
         // Slow average; steady noise raises it and stays closed
         if (mag > avg_r) begin
            avg_nxt = avg_r + ((mag - avg_r) >> amx_pkg::AVG_SH);
         end else begin
            avg_nxt = avg_r - ((avg_r - mag) >> amx_pkg::AVG_SH);
         end
         if (!auto_on) begin
            gain_nxt = amx_pkg::GAIN_OPEN;
         end else if (want_open) begin
            if (gain_r > amx_pkg::GAIN_OPEN - amx_pkg::ATTACK_STEP) begin
               gain_nxt = amx_pkg::GAIN_OPEN;
            end else begin
               gain_nxt = gain_r + amx_pkg::ATTACK_STEP;
            end
         end else if (gain_r <
                      amx_pkg::GAIN_CLOSED + amx_pkg::RELEASE_STEP) begin
            gain_nxt = amx_pkg::GAIN_CLOSED;
         end else begin
            gain_nxt = gain_r - amx_pkg::RELEASE_STEP;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         env_r <= amx_pkg::ENV_RST;
         avg_r <= amx_pkg::AVG_RST;
         gain_r <= amx_pkg::GAIN_RST;
      end else if (clk_en) begin
         env_r <= env_nxt;
         avg_r <= avg_nxt;
         gain_r <= gain_nxt;
      end
   end
endmodule : amx_chan

// ### design/amx_mixer.sv
// Purpose: Automatic mixer of eight inputs onto the left and right tracks.
// Assumes: Trimmed samples and fader gains arrive together per sample.
// Notes: Mixed words queue in a FIFO; a full FIFO stalls the input.
//
// Overview of operation
// - Only post-fade feeds to left and right tracks are automixed.
// - Pre-fade taken after trim, post-fade after the fader gain.
// - An input becoming active reaches open gain within 1 ms.
// - An input going quiet releases smoothly to closed over 500 ms.
// - Any number of automixed inputs may be open together.
// - Inputs below their adaptive threshold sit 20 dB below open gain.
// - Threshold follows each input's running average level.
// - Each open input drops 3 dB per doubling of open inputs.
// - When all fall silent, the last active input stays open.
// - An input below half the level of another active input stays closed.
// - Unique audio at an input opens it only if no active input is over twice as loud.
// - Automixing runs only with the global setting on and auto flags set.
// - Inputs with auto flag cleared stay at open gain.
// - Automixed indicator: bright green open, off closed.
// - Manual post-fade inputs join analysis; indicator dim green metering.
// - Automixing is off above 48.048 kHz sample rate.
`timescale 1ns/1ps
module amx_mixer (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic automix_global_setting,
   input wire logic [17:0] sample_rate_hz,
   input wire logic [amx_pkg::NCH-1:0] auto_flag,
   input wire logic [amx_pkg::NCH-1:0] route_post_l,
   input wire logic [amx_pkg::NCH-1:0] route_post_r,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [amx_pkg::NCH*amx_pkg::SW-1:0] trim_in,
   input wire logic [amx_pkg::NCH*amx_pkg::FW-1:0] fader_in,
   output logic pre_valid,
   output logic [amx_pkg::NCH*amx_pkg::SW-1:0] pre_out,
   output logic out_valid,
   input wire logic out_ready,
   output logic [amx_pkg::SW-1:0] out_l,
   output logic [amx_pkg::SW-1:0] out_r,
   output logic [amx_pkg::NCH-1:0] open_flags,
   output logic [amx_pkg::NCH*2-1:0] led_mode,
   output logic [amx_pkg::NCH*amx_pkg::METER_W-1:0] led_meter
);
   localparam int N = amx_pkg::NCH;
   localparam int SW = amx_pkg::SW;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Saturate a wide signed value to a sample word
   function automatic logic [SW-1:0] sat_w(input logic signed [40:0] v);
      logic signed [40:0] hi;
      logic signed [40:0] lo;
      hi = 41'sd8388607;
      lo = -41'sd8388608;
      if (v > hi) begin
         sat_w = 24'h7FFFFF;
      end else if (v < lo) begin
         sat_w = 24'h800000;
      end else begin
         sat_w = v[SW-1:0];
      end
   endfunction : sat_w

   // Scale a signed sample by an unsigned 16-bit fraction
   function automatic logic [SW-1:0] scale_u16(
      input logic [SW-1:0] s,
      input logic [amx_pkg::CW-1:0] g
   );
      logic signed [40:0] p;
      p = $signed(s) * $signed({1'b0, g});
      scale_u16 = p[amx_pkg::COEF_FRAC +: SW];
   endfunction : scale_u16

   // 1/sqrt(n): 3 dB less per doubling of open inputs
   function automatic logic [amx_pkg::CW-1:0] open_coef(
      input logic [3:0] n
   );
      unique case (n)
         4'h2: open_coef = 16'hB505;
         4'h3: open_coef = 16'h93CD;
         4'h4: open_coef = 16'h8000;
         4'h5: open_coef = 16'h727D;
         4'h6: open_coef = 16'h6883;
         4'h7: open_coef = 16'h60C2;
         4'h8: open_coef = 16'h5A82;
         default: open_coef = 16'hFFFF;
      endcase
   endfunction : open_coef

   ////////////////////////////////////////////////////////////////////////
   // Input stage: pre-fade and post-fade feeds

   logic adv, take, upd;
   logic s1_v_r, s1_v_nxt;
   logic [SW-1:0] pre_r [N];
   logic [SW-1:0] pre_nxt [N];
   logic [SW-1:0] post_r [N];
   logic [SW-1:0] post_nxt [N];
   logic fifo_wr_ready;

   // Stall the input whenever the mixed word cannot be queued
   assign adv = clk_en && (!s1_v_r || fifo_wr_ready);
   assign take = in_valid && adv;
   assign upd = clk_en && s1_v_r && fifo_wr_ready;
   assign in_ready = adv;

   always_comb begin
      logic signed [40:0] prod;
      prod = '0;
      pre_nxt = pre_r;
      post_nxt = post_r;
      s1_v_nxt = s1_v_r;
      if (take) begin
         s1_v_nxt = 1'b1;
         for (int i = 0; i < N; i++) begin
            pre_nxt[i] = trim_in[i*SW +: SW];
            prod = $signed(trim_in[i*SW +: SW])
                 * $signed({1'b0, fader_in[i*amx_pkg::FW +: amx_pkg::FW]});
            post_nxt[i] = sat_w(prod >>> amx_pkg::FADER_FRAC);
         end
      end else if (upd) begin
         s1_v_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         s1_v_r <= 1'b0;
         for (int i = 0; i < N; i++) begin
            pre_r[i] <= '0;
            post_r[i] <= '0;
         end
      end else if (clk_en) begin
         s1_v_r <= s1_v_nxt;
         pre_r <= pre_nxt;
         post_r <= post_nxt;
      end
   end

   assign pre_valid = s1_v_r;
   generate
      for (genvar g = 0; g < N; g++) begin : g_pre
         assign pre_out[g*SW +: SW] = pre_r[g];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Per-input detection and gain

   logic am_on;
   logic [N-1:0] analysed, auto_on, want_open, active;
   logic [SW-1:0] env [N];
   logic [amx_pkg::GW-1:0] gain [N];

   assign am_on = automix_global_setting
               && (sample_rate_hz <= amx_pkg::MAX_AUTO_RATE_HZ);
   assign analysed = route_post_l | route_post_r;
   assign auto_on = am_on ? (auto_flag & analysed) : '0;

   generate
      for (genvar g = 0; g < N; g++) begin : g_chan
         amx_chan u_chan (
            .core_clk(core_clk),
            .rst_b(rst_b),
            .clk_en(clk_en),
            .upd(upd),
            .auto_on(auto_on[g]),
            .want_open(want_open[g]),
            .sample(post_r[g]),
            .env(env[g]),
            .active(active[g]),
            .gain(gain[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Cross-input decisions

   logic [N-1:0] cand, qual, open_now;
   logic any_qual;
   logic [2:0] loud_idx;
   logic [2:0] last_r, last_nxt;
   logic last_v_r, last_v_nxt;
   logic [3:0] n_open;

   always_comb begin
      logic [SW-1:0] loud_env;
      loud_env = '0;
      loud_idx = 3'h0;
      cand = active & analysed;
      qual = cand;
      for (int i = 0; i < N; i++) begin
         // Much louder copy elsewhere means this is pickup of it
         for (int j = 0; j < N; j++) begin
            if (j != i && cand[j] && cand[i]
                && ({1'b0, env[j]} > {env[i], 1'b0})) begin
               qual[i] = 1'b0;
            end
         end
      end
      // Inputs at similar levels all keep qualifying
      for (int i = 0; i < N; i++) begin
         if (qual[i] && env[i] >= loud_env) begin
            loud_env = env[i];
            loud_idx = 3'(i);
         end
      end
      any_qual = qual != '0;
   end

   always_comb begin
      for (int i = 0; i < N; i++) begin
         want_open[i] = qual[i]
            || (!any_qual && last_v_r && last_r == 3'(i));
         open_now[i] = analysed[i]
            && (!auto_on[i] || want_open[i]);
      end
      n_open = '0;
      for (int i = 0; i < N; i++) begin
         n_open = n_open + {3'h0, open_now[i]};
      end
      last_nxt = last_r;
      last_v_nxt = last_v_r;
      if (upd && any_qual) begin
         last_nxt = loud_idx;
         last_v_nxt = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         last_r <= amx_pkg::LAST_RST;
         last_v_r <= 1'b0;
      end else if (clk_en) begin
         last_r <= last_nxt;
         last_v_r <= last_v_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Track mix and output queue

   logic [amx_pkg::CW-1:0] ocoef;
   logic [SW-1:0] mix_l, mix_r;

   assign ocoef = am_on ? open_coef(n_open) : 16'hFFFF;

   always_comb begin
      logic [SW-1:0] c;
      logic signed [40:0] acc_l;
      logic signed [40:0] acc_r;
      c = '0;
      acc_l = '0;
      acc_r = '0;
      for (int i = 0; i < N; i++) begin
         c = scale_u16(post_r[i], gain[i][amx_pkg::GW-1 -: 16]);
         c = scale_u16(c, ocoef);
         if (route_post_l[i]) begin
            acc_l = acc_l + 41'($signed(c));
         end
         if (route_post_r[i]) begin
            acc_r = acc_r + 41'($signed(c));
         end
      end
      mix_l = sat_w(acc_l);
      mix_r = sat_w(acc_r);
   end

   logic [amx_pkg::MIX_W-1:0] rd_word;

   amx_fifo #(
      .W(amx_pkg::MIX_W),
      .DEPTH(amx_pkg::FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .wr_valid(s1_v_r),
      .wr_ready(fifo_wr_ready),
      .wr_data({mix_l, mix_r}),
      .rd_valid(out_valid),
      .rd_ready(out_ready),
      .rd_data(rd_word)
   );

   assign out_l = rd_word[amx_pkg::MIX_W-1 -: SW];
   assign out_r = rd_word[SW-1:0];

   ////////////////////////////////////////////////////////////////////////
   // Activity indicators

   logic [N-1:0] open_r, open_nxt;
   logic [1:0] led_r [N];
   logic [1:0] led_nxt [N];
   logic [amx_pkg::METER_W-1:0] met_r [N];
   logic [amx_pkg::METER_W-1:0] met_nxt [N];

   always_comb begin
      open_nxt = open_r;
      led_nxt = led_r;
      met_nxt = met_r;
      if (upd) begin
         open_nxt = open_now;
         for (int i = 0; i < N; i++) begin
            met_nxt[i] = env[i][SW-2 -: amx_pkg::METER_W];
            if (auto_on[i]) begin
               led_nxt[i] = want_open[i] ? amx_pkg::LED_BRIGHT
                                         : amx_pkg::LED_OFF;
            end else if (am_on && analysed[i]) begin
               led_nxt[i] = amx_pkg::LED_DIM_METER;
            end else begin
               led_nxt[i] = amx_pkg::LED_METER;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         open_r <= '0;
         for (int i = 0; i < N; i++) begin
            led_r[i] <= amx_pkg::LED_METER;
            met_r[i] <= '0;
         end
      end else if (clk_en) begin
         open_r <= open_nxt;
         led_r <= led_nxt;
         met_r <= met_nxt;
      end
   end

   assign open_flags = open_r;
   generate
      for (genvar g = 0; g < N; g++) begin : g_led
         assign led_mode[g*2 +: 2] = led_r[g];
         assign led_meter[g*amx_pkg::METER_W +: amx_pkg::METER_W] =
            met_r[g];
      end
   endgenerate
endmodule : amx_mixer

// ### testbench/amx_mixer_checker.sv
// Purpose: Port-level assertions for the automatic mixer.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Indicator and flag checks follow the per-sample update.
`timescale 1ns/1ps
module amx_mixer_checker (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic automix_global_setting,
   input wire logic [17:0] sample_rate_hz,
   input wire logic [amx_pkg::NCH-1:0] auto_flag,
   input wire logic [amx_pkg::NCH-1:0] route_post_l,
   input wire logic [amx_pkg::NCH-1:0] route_post_r,
   input wire logic in_valid,
   input wire logic in_ready,
   input wire logic [amx_pkg::NCH*amx_pkg::SW-1:0] trim_in,
   input wire logic pre_valid,
   input wire logic [amx_pkg::NCH*amx_pkg::SW-1:0] pre_out,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic [amx_pkg::SW-1:0] out_l,
   input wire logic [amx_pkg::SW-1:0] out_r,
   input wire logic [amx_pkg::NCH-1:0] open_flags,
   input wire logic [amx_pkg::NCH*2-1:0] led_mode
);
   logic auto_off;
   logic [amx_pkg::NCH-1:0] manual_m;
   logic [amx_pkg::NCH-1:0] bright_m;
   always_comb begin
      auto_off = !automix_global_setting
         || sample_rate_hz > amx_pkg::MAX_AUTO_RATE_HZ;
      manual_m = ~auto_flag & (route_post_l | route_post_r);
      for (int i = 0; i < amx_pkg::NCH; i++) begin
         bright_m[i] = led_mode[2*i +: 2] == amx_pkg::LED_BRIGHT;
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   a_ready_gated: assert property (
      !clk_en |-> !in_ready && !out_valid)
      else $error("ready or valid while clock enable low");
   a_take_pre: assert property (
      in_valid && in_ready |=> pre_valid)
      else $error("taken sample not staged");
   a_pre_data: assert property (
      in_valid && in_ready |=> pre_out == $past(trim_in))
      else $error("pre-fade feed differs from trimmed input");
   a_off_leds: assert property (
      clk_en && auto_off && $past(auto_off) && pre_valid && in_ready
      |=> led_mode == 16'hFFFF)
      else $error("indicators not metering with automix off");
   a_manual_open: assert property (
      clk_en && !auto_off && pre_valid && in_ready && $stable(manual_m)
      |=> (open_flags & $past(manual_m)) == $past(manual_m))
      else $error("manual routed input not counted open");
   a_bright_open: assert property (
      (bright_m & ~open_flags) == 8'h00)
      else $error("bright indicator on a closed input");
   a_out_hold: assert property (
      out_valid && !out_ready ##1 clk_en
      |-> out_valid && $stable(out_l) && $stable(out_r))
      else $error("track word changed before taken");
   a_fifo_push: assert property (
      in_valid && in_ready && !out_valid ##1 clk_en [*2] |-> out_valid)
      else $error("mixed word late into queue");
   c_take: cover property (in_valid && in_ready);
   c_full: cover property (clk_en && in_valid && !in_ready);
   c_bright: cover property (bright_m != 8'h00);
endmodule : amx_mixer_checker
bind amx_mixer amx_mixer_checker u_amx_mixer_checker (
   .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
   .automix_global_setting(automix_global_setting),
   .sample_rate_hz(sample_rate_hz), .auto_flag(auto_flag),
   .route_post_l(route_post_l), .route_post_r(route_post_r),
   .in_valid(in_valid), .in_ready(in_ready), .trim_in(trim_in),
   .pre_valid(pre_valid), .pre_out(pre_out), .out_valid(out_valid),
   .out_ready(out_ready), .out_l(out_l), .out_r(out_r),
   .open_flags(open_flags), .led_mode(led_mode)
);

// ### testbench/amx_track_model.sv
// Purpose: Left/right track consumer of mixed words.
// Assumes: Bench raises stall to hold words back in the queue.
// Notes: Ready moves only on the falling edge.
`timescale 1ns/1ps
module amx_track_model (
   input wire logic core_clk,
   input wire logic stall,
   input wire logic out_valid,
   output logic out_ready,
   input wire logic [amx_pkg::SW-1:0] out_l,
   input wire logic [amx_pkg::SW-1:0] out_r,
   output int word_count,
   output logic [amx_pkg::SW-1:0] last_l,
   output logic [amx_pkg::SW-1:0] last_r
);
   initial begin
      out_ready = 1'b0;
      word_count = 0;
      last_l = 24'h000000;
      last_r = 24'h000000;
   end
   always @(negedge core_clk) begin
      out_ready <= !stall;
   end
   // Words kept in pairs, as one sample set
   always @(posedge core_clk) begin
      if (out_valid === 1'b1 && out_ready) begin
         word_count <= word_count + 1;
         last_l <= out_l;
         last_r <= out_r;
      end
   end
endmodule : amx_track_model

// ### testbench/amx_mixer_tb.sv
// Purpose: Self-checking bench for the automatic mixer.
// Assumes: Inputs change on the falling clock edge.
// Notes: Gain ramps are judged through open flags and indicators.
`timescale 1ns/1ps
module amx_mixer_tb;
   localparam int N = amx_pkg::NCH;
   localparam int W = amx_pkg::SW;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   logic automix_global_setting = 1'b0;
   logic [17:0] sample_rate_hz = 18'h0BB80;
   logic [N-1:0] auto_flag = 8'h00;
   logic [N-1:0] route_post_l = 8'h55;
   logic [N-1:0] route_post_r = 8'hAA;
   logic in_valid = 1'b0;
   logic [N*W-1:0] trim_in = '0;
   logic [N*amx_pkg::FW-1:0] fader_in = '0;
   logic stall = 1'b0;
   logic in_ready, pre_valid, out_valid, out_ready;
   logic [N*W-1:0] pre_out;
   logic [W-1:0] out_l, out_r, last_l, last_r;
   logic [N-1:0] open_flags;
   logic [2*N-1:0] led_mode;
   logic [N*amx_pkg::METER_W-1:0] led_meter;
   logic [W-1:0] smp [N];
   logic [15:0] fad [N];
   int word_count;
   int mismatches = 0;
   int check_count = 0;
   int base;
   int seen;
   always #2 core_clk = ~core_clk;
   amx_mixer u_amx_mixer (
      .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
      .automix_global_setting(automix_global_setting),
      .sample_rate_hz(sample_rate_hz), .auto_flag(auto_flag),
      .route_post_l(route_post_l), .route_post_r(route_post_r),
      .in_valid(in_valid), .in_ready(in_ready), .trim_in(trim_in),
      .fader_in(fader_in), .pre_valid(pre_valid), .pre_out(pre_out),
      .out_valid(out_valid), .out_ready(out_ready), .out_l(out_l),
      .out_r(out_r), .open_flags(open_flags), .led_mode(led_mode),
      .led_meter(led_meter)
   );
   amx_track_model u_amx_track_model (
      .core_clk(core_clk), .stall(stall), .out_valid(out_valid),
      .out_ready(out_ready), .out_l(out_l), .out_r(out_r),
      .word_count(word_count), .last_l(last_l), .last_r(last_r)
   );
   ////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic signed [31:0] exp,
      input logic signed [31:0] got, input int tol = 0);
      logic signed [31:0] d;
      check_count++;
      d = got - exp;
      if ((^got === 1'bx) || d > tol || d < -tol) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // n sample sets per call; valid held until the last take edge
   task automatic send(input int n);
      for (int k = 0; k < n; k++) begin
         @(negedge core_clk);
         for (int i = 0; i < N; i++) begin
            trim_in[W*i +: W] = smp[i];
            fader_in[16*i +: 16] = fad[i];
         end
         in_valid = 1'b1;
         for (int t = 0; t < 50 && in_ready !== 1'b1; t++) begin
            @(negedge core_clk);
         end
         check("in_ready", 1, in_ready);
         @(posedge core_clk);
      end
      @(negedge core_clk);
      in_valid = 1'b0;
   endtask : send
   function automatic logic [1:0] led(input int i);
      return led_mode[2*i +: 2];
   endfunction : led
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////
   initial begin
      for (int i = 0; i < N; i++) begin
         smp[i] = 24'h001000 * (i + 1);
         fad[i] = 16'h1000;
      end
      repeat (8) @(negedge core_clk);
      rst_b = 1'b1;
      check("pre_valid", 0, pre_valid);
      check("out_valid", 0, out_valid);
      check("open_flags", 0, open_flags);
      check("led_mode", 32'h0000FFFF, led_mode);
      $display("test reset done");
      // Half fader must change the tracks, never the pre-fade feed
      for (int f = 16'h1000; f >= 16'h0800; f -= 16'h0800) begin
         for (int i = 0; i < N; i++) fad[i] = 16'(f);
         send(1);
         for (int i = 0; i < N; i++) begin
            check("pre_out", smp[i], pre_out[W*i +: W]);
         end
         repeat (4) @(negedge core_clk);
         check("out_l", 16 * f, 32'(signed'(last_l)), 16);
         check("out_r", 20 * f, 32'(signed'(last_r)), 16);
         check("led_mode", 32'h0000FFFF, led_mode);
      end
      $display("test manual mix done");
      automix_global_setting = 1'b1;
      auto_flag = 8'hFF;
      sample_rate_hz = 18'h0BBB1;
      send(2);
      check("led_mode", 32'h0000FFFF, led_mode);
      sample_rate_hz = 18'h0BBB0;
      send(2);
      seen = 0;
      for (int i = 0; i < N; i++) seen += (led(i) == 2'h3);
      check("metering leds", 0, seen);
      $display("test rate limit done");
      for (int i = 0; i < N; i++) smp[i] = 24'h002000;
      send(3000);
      check("open count", 1, $countones(open_flags));
      smp[3] = 24'h200000;
      smp[1] = 24'h180000;
      smp[5] = 24'h080000;
      send(amx_pkg::ATTACK_SAMPLES + 2);
      check("open 3", 1, open_flags[3]);
      check("open 1", 1, open_flags[1]);
      check("open 5", 0, open_flags[5]);
      check("led 3", amx_pkg::LED_BRIGHT, led(3));
      check("led 0", amx_pkg::LED_OFF, led(0));
      // Half fader on 0x200000 gives a 0x100000 level, meter bits 22:15
      check("meter 3", 8'h20, led_meter[31:24], 1);
      for (int i = 0; i < N; i++) smp[i] = 24'h000000;
      send(1000);
      check("lock", 1, $countones(open_flags));
      auto_flag = 8'h7F;
      send(2);
      check("led 7", amx_pkg::LED_DIM_METER, led(7));
      check("open 7", 1, open_flags[7]);
      $display("test automix done");
      // Let the last word leave so the queue starts empty
      repeat (4) @(negedge core_clk);
      stall = 1'b1;
      repeat (2) @(negedge core_clk);
      base = word_count;
      seen = 0;
      in_valid = 1'b1;
      for (int t = 0; t < 20; t++) begin
         seen += (in_ready === 1'b1);
         @(negedge core_clk);
      end
      in_valid = 1'b0;
      check("accepted", amx_pkg::FIFO_DEPTH + 1, seen);
      clk_en = 1'b0;
      @(negedge core_clk);
      check("frozen ready", 0, {in_ready, out_valid});
      clk_en = 1'b1;
      stall = 1'b0;
      repeat (20) @(negedge core_clk);
      check("drained", amx_pkg::FIFO_DEPTH + 1, word_count - base);
      $display("test queue done");
      stop_test();
   end
   initial begin
      #200000;
      mismatches++;
      $display("BAD watchdog expected finish seen timeout");
      stop_test();
   end
endmodule : amx_mixer_tb
